// ### core/host_port_pin_roles.sv
// Purpose: Assign roles to the shared processor-interface pins.
// Assumes: Straps are stable around the release of global_reset_n.
// Notes: All pin outputs are registered; pin inputs pass two flip-flops.
`timescale 1ns/100ps
`default_nettype none
module host_port_pin_roles
  import host_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic global_reset_n,
  input wire logic chip_select_n_i,
  output logic chip_select_n_o,
  output logic chip_select_n_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic cfg_sclk,
  input wire logic cfg_mosi,
  input wire logic cfg_cs_n,
  input wire logic cfg_done,
  output logic cfg_miso,
  output logic cfg_run,
  input wire logic slv_miso,
  input wire logic slv_miso_en,
  output logic slv_cs_n,
  output logic slv_sclk,
  output logic slv_mosi,
  input wire logic i2c_sda_pull_low,
  output logic i2c_scl,
  output logic i2c_sda,
  output logic i2c_addr_bit,
  output logic mode_spi,
  output logic host_ready
);

  logic [SYNC_WIDTH-1:0] sync_vec;
  logic global_reset_n_s;
  logic cs_n_s;
  logic miso_s;
  logic sclk_s;
  logic mosi_s;
  logic global_reset_n_prev_r;
  logic rst_rise;
  logic [1:0] strap_r;
  logic [1:0] strap_now;
  role_state_e state_r;
  role_state_e state_nxt;
  logic [1:0] release_cnt_r;
  iface_mode_e mode_r;
  logic active_spi;
  logic active_i2c;
  logic cs_n_o_nxt;
  logic cs_n_oe_nxt;
  logic miso_o_nxt;
  logic miso_oe_nxt;
  logic sclk_o_nxt;
  logic sclk_oe_nxt;
  logic mosi_o_nxt;
  logic mosi_oe_nxt;

  pin_sync #(
    .WIDTH(SYNC_WIDTH),
    .RST_VAL(SYNC_RST_VAL)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in({global_reset_n, chip_select_n_i, miso_i, sclk_i, mosi_i}),
    .sync_out(sync_vec)
  );

  assign {global_reset_n_s, cs_n_s, miso_s, sclk_s, mosi_s} = sync_vec;
  assign strap_now = {miso_s, cs_n_s};
  assign rst_rise = global_reset_n_s && !global_reset_n_prev_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      global_reset_n_prev_r <= 1'b0;
    end else begin
      global_reset_n_prev_r <= global_reset_n_s;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      strap_r <= STRAP_RST_VAL;
    end else if (rst_rise) begin
      strap_r <= strap_now;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_r <= MODE_I2C;
    end else if (rst_rise) begin
      mode_r <= (strap_now == STRAP_I2C_A || strap_now == STRAP_I2C_B) ? MODE_I2C : MODE_SPI;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RESET: begin
        if (rst_rise) begin
          state_nxt = (strap_now == STRAP_SPI_MASTER) ? ST_AUTOCFG : ST_ACTIVE;
        end
      end
      ST_AUTOCFG: begin
        if (cfg_done) begin
          state_nxt = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (release_cnt_r == RELEASE_LAST_CNT) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        state_nxt = ST_ACTIVE;
      end
      default: begin
        state_nxt = ST_RESET;
      end
    endcase
    if (!global_reset_n_s) begin
      state_nxt = ST_RESET;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= ST_RESET;
      release_cnt_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      release_cnt_r <= (state_r == ST_RELEASE) ? release_cnt_r + 2'h1 : 2'h0;
    end
  end

  assign active_spi = (state_r == ST_ACTIVE) && (mode_r == MODE_SPI);
  assign active_i2c = (state_r == ST_ACTIVE) && (mode_r == MODE_I2C);

  always_comb begin
    cs_n_o_nxt = 1'b1;
    cs_n_oe_nxt = 1'b0;
    miso_o_nxt = 1'b1;
    miso_oe_nxt = 1'b0;
    sclk_o_nxt = 1'b1;
    sclk_oe_nxt = 1'b0;
    mosi_o_nxt = 1'b1;
    mosi_oe_nxt = 1'b0;
    if (state_r == ST_AUTOCFG && global_reset_n_s) begin
      sclk_o_nxt = cfg_sclk;
      sclk_oe_nxt = 1'b1;
      mosi_o_nxt = cfg_mosi;
      mosi_oe_nxt = 1'b1;
      cs_n_o_nxt = cfg_cs_n;
      cs_n_oe_nxt = 1'b1;
    end else if (active_spi && global_reset_n_s) begin
      miso_o_nxt = slv_miso;
      miso_oe_nxt = slv_miso_en;
    end else if (active_i2c && global_reset_n_s) begin
      mosi_o_nxt = 1'b0;
      mosi_oe_nxt = i2c_sda_pull_low;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      chip_select_n_o <= 1'b1;
      chip_select_n_oe <= 1'b0;
      miso_o <= 1'b1;
      miso_oe <= 1'b0;
      sclk_o <= 1'b1;
      sclk_oe <= 1'b0;
      mosi_o <= 1'b1;
      mosi_oe <= 1'b0;
    end else begin
      chip_select_n_o <= cs_n_o_nxt;
      chip_select_n_oe <= cs_n_oe_nxt;
      miso_o <= miso_o_nxt;
      miso_oe <= miso_oe_nxt;
      sclk_o <= sclk_o_nxt;
      sclk_oe <= sclk_oe_nxt;
      mosi_o <= mosi_o_nxt;
      mosi_oe <= mosi_oe_nxt;
    end
  end

  assign cfg_miso = (state_r == ST_AUTOCFG) ? miso_s : 1'b1;
  assign cfg_run = (state_r == ST_AUTOCFG);

  // slave clock and data come from the external master.
  assign slv_sclk = active_spi ? sclk_s : 1'b1;
  // command, address and data arrive on MOSI.
  assign slv_mosi = active_spi ? mosi_s : 1'b1;
  // slave sees no select until fully released.
  assign slv_cs_n = active_spi ? cs_n_s : 1'b1;

  // SCL is only ever an input.
  assign i2c_scl = active_i2c ? sclk_s : 1'b1;
  assign i2c_sda = active_i2c ? mosi_s : 1'b1;

  assign i2c_addr_bit = strap_r[0];
  assign mode_spi = (mode_r == MODE_SPI);
  assign host_ready = (state_r == ST_ACTIVE);

  strap_latch_a: assert property (@(posedge sys_clk) disable iff (srst)
    rst_rise |=> strap_r == $past(strap_now))
    else $error("strap not latched at reset release");

  // MISO not driven while strap is read.
  miso_strap_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state_r == ST_RESET) ##1 (state_r == ST_RESET) |-> !miso_oe)
    else $error("MISO driven during reset");

  miso_drive_a: assert property (@(posedge sys_clk) disable iff (srst)
    (active_spi && global_reset_n_s && slv_miso_en) |=> miso_oe && miso_o == $past(slv_miso))
    else $error("MISO not driven with slave data");

  master_miso_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state_r == ST_AUTOCFG) |-> !miso_oe && cfg_miso == miso_s)
    else $error("MISO not an input during auto-config");

  // no clock from device in I2C.
  i2c_no_clk_a: assert property (@(posedge sys_clk) disable iff (srst)
    (mode_r == MODE_I2C) |-> !sclk_oe)
    else $error("SCL driven in I2C mode");

  sclk_drive_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state_r == ST_AUTOCFG && global_reset_n_s) ##1 (state_r == ST_AUTOCFG) |-> sclk_oe && sclk_o == $past(cfg_sclk))
    else $error("SCLK not driven during auto-config");

  sda_open_drain_a: assert property (@(posedge sys_clk) disable iff (srst)
    (mode_r == MODE_I2C && mosi_oe) |-> !mosi_o)
    else $error("SDA driven high");

  mosi_drive_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state_r == ST_AUTOCFG && global_reset_n_s) |=> mosi_oe && mosi_o == $past(cfg_mosi))
    else $error("MOSI not driven during auto-config");

  decode_slave_a: assert property (@(posedge sys_clk) disable iff (srst)
    (rst_rise && strap_now == STRAP_SPI_SLAVE) |=> mode_r == MODE_SPI && state_r == ST_ACTIVE)
    else $error("strap 10 not decoded as SPI slave");

  // chip select is an input in normal operation.
  cs_input_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state_r == ST_ACTIVE) ##1 (state_r == ST_ACTIVE) |-> !chip_select_n_oe)
    else $error("chip select driven after auto-config");

  release_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state_r == ST_AUTOCFG && cfg_done && global_reset_n_s) |=> ##1 !sclk_oe && !mosi_oe && !chip_select_n_oe && slv_cs_n)
    else $error("drivers not released after auto-config");

  cover_master_c: cover property (@(posedge sys_clk) disable iff (srst)
    (state_r == ST_AUTOCFG) ##[1:50] (state_r == ST_ACTIVE));
  cover_i2c_c: cover property (@(posedge sys_clk) disable iff (srst)
    rst_rise && strap_now == STRAP_I2C_B);
  cover_slave_read_c: cover property (@(posedge sys_clk) disable iff (srst)
    active_spi && miso_oe);

endmodule : host_port_pin_roles
`default_nettype wire

// ### core/host_port_pkg.sv
// Purpose: Shared constants and types for the host port pin role logic.
// Assumes: One clock domain, sys_clk at 125 MHz.
// Notes: Strap codes are {iface_strap_high, iface_strap_low}.
package host_port_pkg;

  localparam int SYNC_WIDTH = 5;
  // Sync vector order: {global_reset_n, chip_select_n, miso, sclk, mosi}.
  // Pins idle high through pull-ups; reset pin idles asserted.
  localparam logic [SYNC_WIDTH-1:0] SYNC_RST_VAL = 5'h0f;
  localparam logic [1:0] STRAP_RST_VAL = 2'h0;

  localparam logic [1:0] STRAP_I2C_A = 2'h0;
  localparam logic [1:0] STRAP_I2C_B = 2'h1;
  localparam logic [1:0] STRAP_SPI_SLAVE = 2'h2;
  localparam logic [1:0] STRAP_SPI_MASTER = 2'h3;
  // Release lasts three cycles, so the synchronisers show the let-go pins before the slave core listens.
  localparam logic [1:0] RELEASE_LAST_CNT = 2'h2;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_AUTOCFG = 2'b01,
    ST_RELEASE = 2'b11,
    ST_ACTIVE = 2'b10
  } role_state_e;

  typedef enum logic {
    MODE_I2C = 1'b0,
    MODE_SPI = 1'b1
  } iface_mode_e;

endpackage : host_port_pkg

// ### core/pin_sync.sv
// Purpose: Two-stage synchroniser for a vector of asynchronous pin levels.
// Assumes: Each bit is an independent level; no bus coherence is needed.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none
module pin_sync
  import host_port_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : pin_sync
`default_nettype wire

// ### dv/far_side_model.sv
// Purpose: Pins, pull-ups, straps, external master and serial EEPROM.
// Assumes: All pin lines are pulled up when nobody drives them.
// Notes: The EEPROM shifts rom_byte out MSB first, changing on SCLK fall.
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
  input wire logic strap_en,
  input wire logic [1:0] strap,
  input wire logic mst_en,
  input wire logic mst_cs_n,
  input wire logic mst_sclk,
  input wire logic mst_mosi,
  input wire logic [7:0] rom_byte,
  input wire logic cs_o,
  input wire logic cs_oe,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic sclk_o,
  input wire logic sclk_oe,
  input wire logic mosi_o,
  input wire logic mosi_oe,
  output logic cs_pin,
  output logic miso_pin,
  output logic sclk_pin,
  output logic mosi_pin
);
  logic [2:0] idx = 3'h0;
  logic eep_sel;
  assign eep_sel = cs_oe & ~cs_o;
  always @(negedge sclk_pin or negedge eep_sel) begin
    if (!eep_sel) idx <= 3'h0;
    else idx <= idx + 3'h1;
  end
  assign cs_pin = cs_oe ? cs_o : strap_en ? strap[0] : mst_en ? mst_cs_n : 1'b1;
  assign miso_pin = miso_oe ? miso_o : strap_en ? strap[1] : eep_sel ? rom_byte[3'h7 - idx] : 1'b1;
  assign sclk_pin = sclk_oe ? sclk_o : mst_en ? mst_sclk : 1'b1;
  assign mosi_pin = (mosi_oe ? mosi_o : 1'b1) & (mst_en ? mst_mosi : 1'b1);
endmodule : far_side_model
`default_nettype wire

// ### dv/test_host_port_pin_roles.sv
// Purpose: Self-checking bench for the host port pin roles.
// Assumes: Pin outputs lag their sources by one cycle, inputs by two.
// Notes: Each strap code is exercised through a full reset release.
`timescale 1ns/100ps
`default_nettype none
module test_host_port_pin_roles
  import host_port_pkg::*;
;
  logic sys_clk, srst, global_reset_n, strap_en, mst_en, mst_cs_n, mst_sclk, mst_mosi;
  logic [1:0] strap;
  logic cfg_sclk, cfg_mosi, cfg_cs_n, cfg_done, slv_miso, slv_miso_en, i2c_sda_pull_low;
  logic cs_i, cs_o, cs_oe, miso_i, miso_o, miso_oe, sclk_i, sclk_o, sclk_oe, mosi_i, mosi_o, mosi_oe;
  logic cfg_miso, cfg_run, slv_cs_n, slv_sclk, slv_mosi, i2c_scl, i2c_sda, i2c_addr_bit, mode_spi, host_ready;
  logic [7:0] rom_byte = 8'hb4;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  far_side_model far (.strap_en(strap_en), .strap(strap), .mst_en(mst_en), .mst_cs_n(mst_cs_n),
    .mst_sclk(mst_sclk), .mst_mosi(mst_mosi), .rom_byte(rom_byte), .cs_o(cs_o), .cs_oe(cs_oe),
    .miso_o(miso_o), .miso_oe(miso_oe), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .cs_pin(cs_i), .miso_pin(miso_i), .sclk_pin(sclk_i), .mosi_pin(mosi_i));
  host_port_pin_roles dut (.sys_clk(sys_clk), .srst(srst), .global_reset_n(global_reset_n),
    .chip_select_n_i(cs_i), .chip_select_n_o(cs_o), .chip_select_n_oe(cs_oe), .miso_i(miso_i),
    .miso_o(miso_o), .miso_oe(miso_oe), .sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
    .mosi_i(mosi_i), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .cfg_sclk(cfg_sclk), .cfg_mosi(cfg_mosi),
    .cfg_cs_n(cfg_cs_n), .cfg_done(cfg_done), .cfg_miso(cfg_miso), .cfg_run(cfg_run),
    .slv_miso(slv_miso), .slv_miso_en(slv_miso_en), .slv_cs_n(slv_cs_n), .slv_sclk(slv_sclk),
    .slv_mosi(slv_mosi), .i2c_sda_pull_low(i2c_sda_pull_low), .i2c_scl(i2c_scl), .i2c_sda(i2c_sda),
    .i2c_addr_bit(i2c_addr_bit), .mode_spi(mode_spi), .host_ready(host_ready));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic check(input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic do_reset(input logic [1:0] s);
    strap_en <= 1'b1;
    strap <= s;
    global_reset_n <= 1'b0;
    cyc(6);
    check(cs_oe | miso_oe | sclk_oe | mosi_oe, 1'b0); // pins are inputs in reset
    global_reset_n <= 1'b1;
    cyc(6);
    strap_en <= 1'b0;
    cyc(2);
    check(mode_spi, s[1]); // strap decode
    if (!s[1]) check(i2c_addr_bit, s[0]); // address bit
    check(cfg_run, s == STRAP_SPI_MASTER); // master only on 11
    check(host_ready, ~&s); // host held off in auto-config
  endtask : do_reset
  task automatic t_i2c(input logic [1:0] s);
    do_reset(s);
    mst_en <= 1'b1;
    mst_sclk <= 1'b0;
    cyc(4);
    check(i2c_scl, 1'b0); // clock from master
    check(sclk_oe, 1'b0); // device never drives SCL
    check(i2c_sda, 1'b1); // idle data high
    i2c_sda_pull_low <= 1'b1;
    cyc(4);
    check(mosi_oe & ~mosi_o, 1'b1); // device pulls low
    check(i2c_sda, 1'b0); // shared line seen low
    i2c_sda_pull_low <= 1'b0;
    mst_mosi <= 1'b0;
    cyc(4);
    check(mosi_oe, 1'b0); // device released
    check(i2c_sda, 1'b0); // master pulls low
    mst_en <= 1'b0;
    mst_mosi <= 1'b1;
  endtask : t_i2c
  task automatic t_slave;
    do_reset(2'h2);
    mst_en <= 1'b1;
    mst_cs_n <= 1'b0;
    mst_sclk <= 1'b0;
    mst_mosi <= 1'b0;
    cyc(4);
    check(slv_cs_n | slv_sclk | slv_mosi, 1'b0); // pins reach slave core
    check(sclk_oe | mosi_oe | cs_oe, 1'b0); // clock is an input
    check(miso_oe, 1'b0); // strap pin released
    for (int b = 0; b < 2; b++) begin
      slv_miso_en <= 1'b1;
      slv_miso <= b[0];
      cyc(3);
      check(miso_oe, 1'b1); // pin drives read data
      check(miso_o, b[0]); // read data value
    end
    slv_miso_en <= 1'b0;
    mst_en <= 1'b0;
    cyc(3);
    check(miso_oe, 1'b0); // released after read
  endtask : t_slave
  task automatic t_master;
    do_reset(2'h3);
    check(slv_cs_n, 1'b1); // slave refused during auto-config
    cfg_cs_n <= 1'b0;
    cyc(6);
    check(cs_oe & ~cs_o, 1'b1); // chip select driven low
    for (int i = 7; i >= 0; i--) begin
      check(cfg_miso, rom_byte[i]); // EEPROM data captured
      cfg_mosi <= rom_byte[i];
      cfg_sclk <= 1'b1;
      cyc(4);
      check(sclk_oe & sclk_o, 1'b1); // clock driven out
      check(mosi_oe, 1'b1); // command line driven
      check(mosi_o, rom_byte[i]); // bit sent
      cfg_sclk <= 1'b0;
      cyc(4);
    end
    cfg_cs_n <= 1'b1;
    cfg_done <= 1'b1;
    cyc(1);
    cfg_done <= 1'b0;
    cyc(2);
    check(host_ready | ~slv_cs_n, 1'b0); // host held off while pins settle
    cyc(2);
    check(cs_oe | sclk_oe | mosi_oe | miso_oe, 1'b0); // drivers released
    check(host_ready, 1'b1); // slave role afterwards
    check(cfg_run, 1'b0); // auto-config stopped
    mst_en <= 1'b1;
    mst_cs_n <= 1'b0;
    cyc(4);
    check(slv_cs_n | slv_sclk | slv_mosi, 1'b0); // slave pins reach core
    mst_en <= 1'b0;
  endtask : t_master
  initial begin
    srst = 1'b1;
    global_reset_n = 1'b0;
    strap_en = 1'b1;
    strap = 2'h0;
    {mst_en, mst_cs_n, mst_sclk, mst_mosi} = 4'h7;
    {cfg_sclk, cfg_mosi, cfg_cs_n, cfg_done} = 4'h2;
    {slv_miso, slv_miso_en, i2c_sda_pull_low} = 3'h0;
    cyc(4);
    srst <= 1'b0;
    t_i2c(2'h0);
    t_i2c(2'h1);
    t_slave();
    t_master();
    summarize();
  end
endmodule : test_host_port_pin_roles
`default_nettype wire
